/* gasr_defs.vh */
`ifndef GASR_DEFS_VH
`define GASR_DEFS_VH

// register indices; byte address is four times the index
`define GASR_IDX_NEXT_PAGE    6'h08
`define GASR_IDX_ROLE_CTRL    6'h09
`define GASR_IDX_ROLE_STAT    6'h0a
`define GASR_IDX_EXT_STAT     6'h0f
`define GASR_IDX_AUX_CTRL     6'h1c

// received next page fields and reset value
`define GASR_NP_MORE_BIT      15
`define GASR_NP_ACK_BIT       14
`define GASR_NP_MSG_BIT       13
`define GASR_NP_ACK2_BIT      12
`define GASR_NP_TOGGLE_BIT    11
`define GASR_NP_RESET         16'h2000

// role and test control fields
`define GASR_CT_TEST_HI       15
`define GASR_CT_TEST_LO       13
`define GASR_CT_MAN_EN_BIT    12
`define GASR_CT_MAN_VAL_BIT   11
`define GASR_CT_PORT_BIT      10
`define GASR_CT_ADV_FD_BIT    9
`define GASR_CT_ADV_HD_BIT    8
`define GASR_TEST_NORMAL      3'h0
`define GASR_TEST_LAST        3'h4

// role and test status fields
`define GASR_ST_FAULT_BIT     15
`define GASR_ST_ROLE_BIT      14
`define GASR_ST_LOC_OK_BIT    13
`define GASR_ST_REM_OK_BIT    12
`define GASR_ST_LP_FD_BIT     11
`define GASR_ST_LP_HD_BIT     10
`define GASR_IDLE_ERR_ZERO    8'h00
`define GASR_IDLE_ERR_MAX     8'hff

// extended ability status, fixed
`define GASR_EXT_STAT_VALUE   16'h3000

// auxiliary control fields (self-clearing)
`define GASR_AUX_SOFT_RST_BIT 0
`define GASR_AUX_LOGIC_RST_BIT 1

`endif

/* gasr_regs.v */
// Local design decision: register access over Avalon-MM.
`timescale 1ns/100ps
`include "gasr_defs.vh"

module gasr_regs (
  input  wire        clock,
  input  wire        rst_n,
  input  wire        clkEn,
  input  wire [7:0]  address,
  input  wire        read,
  input  wire        write,
  input  wire [3:0]  byteenable,
  input  wire [31:0] writedata,
  output reg  [31:0] readdata,
  output wire        waitrequest,
  input  wire [1:0]  modeStrap,
  input  wire        pageRxValid,
  input  wire [15:0] pageRxWord,
  input  wire        pageRxFlag,
  input  wire        partnerGigFullIn,
  input  wire        partnerGigHalfIn,
  input  wire        roleFaultIn,
  input  wire        roleMasterIn,
  input  wire        localRxOkIn,
  input  wire        remoteRxOkIn,
  input  wire        idleErrIn,
  output reg  [2:0]  testMode,
  output reg         manualRoleEn,
  output reg         manualRoleMaster,
  output reg         multiPortType,
  output reg         advGigFull,
  output reg         advGigHalf,
  output reg         idleErrOverflow,
  output reg         logicResetPulse
);

  // bus handshake
  reg         ackPend_q;
  reg         ackPend_d;
  wire        busReq;
  wire        busDone;
  wire        rdDone;
  wire        wrDone;
  wire [5:0]  regIdx;
  wire        addrAligned;
  wire        hitNextPage;
  wire        hitRoleCtrl;
  wire        hitRoleStat;
  wire        hitExtStat;
  wire        hitAuxCtrl;

  // register state
  reg  [15:0] nextPage_q;
  reg  [15:0] nextPage_d;
  reg  [7:0]  ctrlHi_q;
  reg  [7:0]  ctrlHi_d;
  reg         fault_q;
  reg         fault_d;
  reg         lpFull_q;
  reg         lpFull_d;
  reg         lpHalf_q;
  reg         lpHalf_d;
  reg  [7:0]  idleCnt_q;
  reg  [7:0]  idleCnt_d;
  reg         strapLoaded_q;
  reg  [31:0] rdData_d;

  // next values of the registered control outputs
  reg  [2:0]  testMode_d;
  reg         manualRoleEn_d;
  reg         manualRoleMaster_d;
  reg         multiPortType_d;
  reg         advGigFull_d;
  reg         advGigHalf_d;
  reg         idleErrOverflow_d;
  reg         logicResetPulse_d;

  wire [15:0] statusWord;
  wire [15:0] ctrlWord;
  wire [4:0]  strapCtrl;
  wire        softRst;
  wire        logicRst;
  wire        anyCntClr;
  wire        idleSat;
  wire        statRead;

  assign busReq      = read | write;
  // one wait cycle: the answer is prepared one edge after the request;
  // a frozen clock enable must hold the master too, or it would finish
  // a transfer that the registers never see
  assign waitrequest = busReq & (~ackPend_q | ~clkEn);
  assign busDone     = busReq & ackPend_q & clkEn;
  assign rdDone      = busDone & read;
  assign wrDone      = busDone & write;

  assign regIdx      = address[7:2];
  assign addrAligned = (address[1:0] == 2'h0);
  assign hitNextPage = addrAligned & (regIdx == `GASR_IDX_NEXT_PAGE);
  assign hitRoleCtrl = addrAligned & (regIdx == `GASR_IDX_ROLE_CTRL);
  assign hitRoleStat = addrAligned & (regIdx == `GASR_IDX_ROLE_STAT);
  assign hitExtStat  = addrAligned & (regIdx == `GASR_IDX_EXT_STAT);
  assign hitAuxCtrl  = addrAligned & (regIdx == `GASR_IDX_AUX_CTRL);

  // self-clearing strobes out of the auxiliary control word
  assign softRst  = wrDone & hitAuxCtrl & byteenable[0] &
                    writedata[`GASR_AUX_SOFT_RST_BIT];
  assign logicRst = wrDone & hitAuxCtrl & byteenable[0] &
                    writedata[`GASR_AUX_LOGIC_RST_BIT];
  assign statRead = rdDone & hitRoleStat;
  assign anyCntClr = statRead | softRst | logicRst;

  // strap decode: bit 1 forces manual mode, bit 0 picks master and
  // multiport; gigabit full always advertised, half only in auto mode
  assign strapCtrl = {modeStrap[1],
                      modeStrap[0],
                      modeStrap[0],
                      1'b1,
                      ~modeStrap[1]};

  assign ctrlWord = {ctrlHi_q, 8'h00};

  assign idleSat = (idleCnt_q == `GASR_IDLE_ERR_MAX);

  assign statusWord = {fault_q,
                       roleMasterIn,
                       localRxOkIn,
                       remoteRxOkIn,
                       lpFull_q,
                       lpHalf_q,
                       2'h0,
                       idleCnt_q};

  always @* begin
    ackPend_d = 1'b0;
    if (busReq && !ackPend_q) begin
      ackPend_d = 1'b1;
    end
  end

  // read data, captured one edge before the master samples it
  always @* begin
    rdData_d = 32'h00000000;
    case ({addrAligned, regIdx})
      {1'b1, `GASR_IDX_NEXT_PAGE}: begin
        rdData_d = {16'h0000, nextPage_q};
      end
      {1'b1, `GASR_IDX_ROLE_CTRL}: begin
        rdData_d = {16'h0000, ctrlWord};
      end
      {1'b1, `GASR_IDX_ROLE_STAT}: begin
        rdData_d = {16'h0000, statusWord};
      end
      {1'b1, `GASR_IDX_EXT_STAT}: begin
        rdData_d = {16'h0000, `GASR_EXT_STAT_VALUE};
      end
      default: begin
        // unmapped, misaligned and aux control all read zero
        rdData_d = 32'h00000000;
      end
    endcase
  end

  // partner page: no bus write path exists, so the word is read-only
  always @* begin
    nextPage_d = nextPage_q;
    if (softRst) begin
      nextPage_d = `GASR_NP_RESET;
    end else if (pageRxValid) begin
      nextPage_d = pageRxWord;
    end
  end

  // control high byte; the reserved low byte is never stored
  always @* begin
    ctrlHi_d = ctrlHi_q;
    if (softRst || !strapLoaded_q) begin
      ctrlHi_d = {`GASR_TEST_NORMAL, strapCtrl};
    end else if (wrDone && hitRoleCtrl && byteenable[1]) begin
      ctrlHi_d = writedata[15:8];
    end
  end

  // latched fault: an event in the read cycle keeps the bit set
  always @* begin
    fault_d = fault_q;
    if (softRst) begin
      fault_d = 1'b0;
    end else if (statRead) begin
      fault_d = roleFaultIn;
    end else if (roleFaultIn) begin
      fault_d = 1'b1;
    end
  end

  // partner gigabit abilities only taken while a page is received
  always @* begin
    lpFull_d = lpFull_q;
    lpHalf_d = lpHalf_q;
    if (softRst) begin
      lpFull_d = 1'b0;
      lpHalf_d = 1'b0;
    end else if (pageRxFlag) begin
      lpFull_d = partnerGigFullIn;
      lpHalf_d = partnerGigHalfIn;
    end
  end

  // idle error counter; an error in the clearing cycle counts as one
  always @* begin
    idleCnt_d = idleCnt_q;
    if (anyCntClr) begin
      if (idleErrIn) begin
        idleCnt_d = 8'h01;
      end else begin
        idleCnt_d = `GASR_IDLE_ERR_ZERO;
      end
    end else if (idleErrIn && !idleSat) begin
      idleCnt_d = idleCnt_q + 8'h01;
    end
  end

  // bus handshake and read data
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ackPend_q <= 1'b0;
      readdata  <= 32'h00000000;
    end else if (clkEn) begin
      ackPend_q <= ackPend_d;
      if (busReq && !ackPend_q) begin
        readdata <= rdData_d;
      end
    end
  end

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      nextPage_q <= `GASR_NP_RESET;
    end else if (clkEn) begin
      nextPage_q <= nextPage_d;
    end
  end

  // control byte starts at zero and takes the straps one edge later,
  // so the straps need only settle by the end of reset
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrlHi_q      <= 8'h00;
      strapLoaded_q <= 1'b0;
    end else if (clkEn) begin
      ctrlHi_q      <= ctrlHi_d;
      // straps are sampled on the first enabled edge after release
      strapLoaded_q <= 1'b1;
    end
  end

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      fault_q  <= 1'b0;
      lpFull_q <= 1'b0;
      lpHalf_q <= 1'b0;
    end else if (clkEn) begin
      fault_q  <= fault_d;
      lpFull_q <= lpFull_d;
      lpHalf_q <= lpHalf_d;
    end
  end

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      idleCnt_q <= `GASR_IDLE_ERR_ZERO;
    end else if (clkEn) begin
      idleCnt_q <= idleCnt_d;
    end
  end

  // control outputs, registered so downstream sees clean levels;
  // next values are worked out here and the flops only copy them
  always @* begin
    testMode_d = ctrlHi_q[7:5];
    // reserved codes fall back to normal so the line is never
    // driven with an undefined pattern
    if (ctrlHi_q[7:5] > `GASR_TEST_LAST) begin
      testMode_d = `GASR_TEST_NORMAL;
    end
    manualRoleEn_d = ctrlHi_q[4];
    // role and port type act only while the enable bit reads zero,
    // as the register defines them; a zero otherwise
    manualRoleMaster_d = ctrlHi_q[3] & ~ctrlHi_q[4];
    multiPortType_d    = ctrlHi_q[2] & ~ctrlHi_q[4];
    advGigFull_d       = ctrlHi_q[1];
    advGigHalf_d       = ctrlHi_q[0];
    // a level, not a pulse, so a slow interrupt path cannot miss it
    idleErrOverflow_d  = (idleCnt_d == `GASR_IDLE_ERR_MAX);
    logicResetPulse_d  = logicRst;
  end

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      testMode         <= `GASR_TEST_NORMAL;
      manualRoleEn     <= 1'b0;
      manualRoleMaster <= 1'b0;
      multiPortType    <= 1'b0;
      advGigFull       <= 1'b0;
      advGigHalf       <= 1'b0;
      idleErrOverflow  <= 1'b0;
      logicResetPulse  <= 1'b0;
    end else if (clkEn) begin
      testMode         <= testMode_d;
      manualRoleEn     <= manualRoleEn_d;
      manualRoleMaster <= manualRoleMaster_d;
      multiPortType    <= multiPortType_d;
      advGigFull       <= advGigFull_d;
      advGigHalf       <= advGigHalf_d;
      idleErrOverflow  <= idleErrOverflow_d;
      logicResetPulse  <= logicResetPulse_d;
    end
  end

endmodule

/* gasr_regs_chk.sv */
`timescale 1ns/100ps
module gasr_regs_chk (
  input wire        clock,
  input wire        rst_n,
  input wire [7:0]  address,
  input wire        read,
  input wire        write,
  input wire [31:0] writedata,
  input wire [31:0] readdata,
  input wire        waitrequest,
  input wire [2:0]  testMode,
  input wire        manualRoleEn,
  input wire        manualRoleMaster,
  input wire        multiPortType,
  input wire        advGigFull,
  input wire        idleErrOverflow
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // outputs may lag the register by a cycle, so look two edges on
  wire rdDone = read && !waitrequest;
  wire wrCtl  = write && !waitrequest && address == 8'h24;
  chk_test_range: assert property (testMode <= 3'h4)
    else $error("reserved test code driven");
  chk_test_load: assert property (wrCtl && writedata[15:13] <= 3'h4
    |-> ##2 testMode == $past(writedata[15:13], 2)) else $error("test");
  chk_manual_load: assert property (wrCtl
    |-> ##2 manualRoleEn == $past(writedata[12], 2)) else $error("man");
  chk_role_gate: assert property (wrCtl |-> ##2 manualRoleMaster ==
    ($past(writedata[11], 2) && !$past(writedata[12], 2))) else $error("rol");
  chk_port_gate: assert property (manualRoleEn |-> !multiPortType)
    else $error("port type not gated");
  chk_adv_load: assert property (wrCtl
    |-> ##2 advGigFull == $past(writedata[9], 2)) else $error("adv");
  chk_ctl_rsvd: assert property (rdDone && address == 8'h24
    |-> readdata[7:0] == 8'h00) else $error("reserved ctrl bits");
  chk_ext_const: assert property (rdDone && address == 8'h3c
    |-> readdata[15:12] == 4'h3) else $error("ext status");
  chk_ovf_hold: assert property (idleErrOverflow && !read && !write
    |=> idleErrOverflow) else $error("overflow dropped");
  chk_cnt_clear: assert property (rdDone && address == 8'h28
    |-> ##2 !idleErrOverflow) else $error("count not cleared");
endmodule
bind gasr_regs gasr_regs_chk chk (.clock(clock), .rst_n(rst_n),
  .address(address), .read(read), .write(write), .writedata(writedata),
  .readdata(readdata), .waitrequest(waitrequest), .testMode(testMode),
  .manualRoleEn(manualRoleEn), .manualRoleMaster(manualRoleMaster),
  .multiPortType(multiPortType), .advGigFull(advGigFull),
  .idleErrOverflow(idleErrOverflow));

/* gasr_partner.sv */
`timescale 1ns/100ps
module gasr_partner (
  input  wire        clock,
  output reg         pageRxValid,
  output reg  [15:0] pageRxWord,
  output reg         pageRxFlag,
  output reg         partnerGigFullIn,
  output reg         partnerGigHalfIn,
  output reg         roleFaultIn,
  output reg         roleMasterIn,
  output reg         localRxOkIn,
  output reg         remoteRxOkIn,
  output reg         idleErrIn
);
  initial {pageRxValid, pageRxWord, pageRxFlag, partnerGigFullIn,
    partnerGigHalfIn, roleFaultIn, roleMasterIn, localRxOkIn,
    remoteRxOkIn, idleErrIn} = 0;
  task setLive(input [4:0] v);
    @(posedge clock);
    {roleMasterIn, localRxOkIn, remoteRxOkIn, partnerGigFullIn,
      partnerGigHalfIn} <= v;
  endtask
  task sendPage(input [15:0] w);
    @(posedge clock);
    pageRxWord  <= w;
    pageRxValid <= 1'b1;
    pageRxFlag  <= 1'b1;
    @(posedge clock);
    pageRxValid <= 1'b0;
    // word is stale now, so show garbage rather than hold it
    pageRxWord  <= ~w;
  endtask
  task fault;
    @(posedge clock);
    roleFaultIn <= 1'b1;
    repeat (3) @(posedge clock);
    roleFaultIn <= 1'b0;
  endtask
  task idleErrs(input integer n);
    repeat (n) begin
      @(posedge clock);
      idleErrIn <= 1'b1;
      @(posedge clock);
      idleErrIn <= 1'b0;
    end
  endtask
endmodule

/* gasr_regs_tb.sv */
`timescale 1ns/100ps
module gasr_regs_tb;
  reg         clock = 1'b0;
  reg         rst_n = 1'b0;
  reg         read = 1'b0;
  reg         write = 1'b0;
  reg  [7:0]  address = 8'h00;
  reg  [31:0] writedata = 32'h0;
  reg  [1:0]  modeStrap = 2'h0;
  reg         clkEn = 1'b1;
  wire        lrp;
  wire [31:0] readdata;
  wire        waitrequest, pv, pf, gf, gh, rf, rm, lo, ro, ie;
  wire [15:0] pw;
  wire [2:0]  testMode;
  wire        mre, mrm, mpt, agf, agh, ovf;
  integer     bad_count = 0;
  integer     checks = 0;
  integer     cyc = 0;
  integer     i, k;
  reg  [15:0] expQ [$];
  reg  [15:0] ctl;
  reg  [31:0] r;
  gasr_partner p (.clock(clock), .pageRxValid(pv), .pageRxWord(pw),
    .pageRxFlag(pf), .partnerGigFullIn(gf), .partnerGigHalfIn(gh),
    .roleFaultIn(rf), .roleMasterIn(rm), .localRxOkIn(lo),
    .remoteRxOkIn(ro), .idleErrIn(ie));
  gasr_regs uut (.clock(clock), .rst_n(rst_n), .clkEn(clkEn),
    .address(address), .read(read), .write(write), .byteenable(4'hf),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .modeStrap(modeStrap), .pageRxValid(pv), .pageRxWord(pw),
    .pageRxFlag(pf), .partnerGigFullIn(gf), .partnerGigHalfIn(gh),
    .roleFaultIn(rf), .roleMasterIn(rm), .localRxOkIn(lo),
    .remoteRxOkIn(ro), .idleErrIn(ie), .testMode(testMode),
    .manualRoleEn(mre), .manualRoleMaster(mrm), .multiPortType(mpt),
    .advGigFull(agf), .advGigHalf(agh), .idleErrOverflow(ovf),
    .logicResetPulse(lrp));
  task chk(input [15:0] e, input [15:0] s, input [8*8:1] nm);
    checks = checks + 1;
    if (s !== e) begin
      bad_count = bad_count + 1;
      $display("wrong value %0s exp %h seen %h", nm, e, s);
    end
  endtask
  task close_out;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // for reads d is the expected word, checked when the answer lands
  task bus(input wr, input [7:0] a, input [15:0] d);
    @(posedge clock);
    address   <= a;
    writedata <= {16'h0, d};
    write     <= wr;
    read      <= !wr;
    if (!wr) expQ.push_back(d);
    @(posedge clock);
    // ends when waitrequest drops; the bench timeout at cycle 5000 ends a wait that never does
    while (waitrequest !== 1'b0) @(posedge clock);
    read  <= 1'b0;
    write <= 1'b0;
  endtask
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      bad_count = bad_count + 1;
      close_out;
    end
    if (read && waitrequest === 1'b0) begin
      if (expQ.size() == 0) bad_count = bad_count + 1;
      else chk(expQ.pop_front(), readdata[15:0], "readdata");
    end
  end
  initial forever #4 clock = ~clock;
  initial begin
    r = $urandom(32'hf5cc3723);
    modeStrap = r[1:0];
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    ctl = {3'h0, r[1], r[0], r[0], 1'b1, ~r[1], 8'h00};
    bus(0, 8'h24, ctl);
    bus(0, 8'h20, 16'h2000);
    bus(0, 8'h3c, 16'h3000);
    bus(0, 8'h28, 16'h0000);
    bus(0, 8'h40, 16'h0000);
    bus(1, 8'h20, r[31:16]);
    bus(0, 8'h20, 16'h2000);
    for (i = 0; i < 8; i = i + 1) begin
      r = $urandom;
      ctl = {i[2:0], r[12:8], 8'h00};
      bus(1, 8'h24, {ctl[15:8], r[7:0]});
      if (i < 5) bus(0, 8'h24, ctl);
      repeat (2) @(posedge clock);
      chk({8'h0, (i < 5 ? i[2:0] : 3'h0), ctl[12], ctl[11] & ~ctl[12],
        ctl[10] & ~ctl[12], ctl[9:8]}, {8'h0, testMode, mre, mrm, mpt,
        agf, agh}, "ctlOuts");
    end
    bus(1, 8'h24, 16'h0000);
    r = $urandom;
    p.setLive(r[20:16]);
    p.sendPage(r[15:0]);
    bus(0, 8'h20, r[15:0]);
    bus(0, 8'h28, {1'b0, r[20:16], 10'h000});
    p.fault;
    bus(0, 8'h28, {1'b1, r[20:16], 10'h000});
    bus(0, 8'h28, {1'b0, r[20:16], 10'h000});
    k = 1 + r[24:21];
    p.idleErrs(k);
    bus(0, 8'h28, {1'b0, r[20:16], 2'b00, k[7:0]});
    bus(0, 8'h28, {1'b0, r[20:16], 10'h000});
    p.idleErrs(300);
    repeat (2) @(posedge clock);
    chk(16'h0001, {15'h0, ovf}, "overflow");
    bus(0, 8'h28, {1'b0, r[20:16], 10'h0ff});
    bus(0, 8'h28, {1'b0, r[20:16], 10'h000});
    p.idleErrs(3);
    bus(1, 8'h70, 16'h0002);
    @(posedge clock);
    chk(16'h0001, {15'h0, lrp}, "logicRst");
    bus(0, 8'h28, {1'b0, r[20:16], 10'h000});
    bus(1, 8'h24, 16'hff00);
    bus(1, 8'h70, 16'h0001);
    ctl = {3'h0, modeStrap[1], modeStrap[0], modeStrap[0], 1'b1,
      ~modeStrap[1], 8'h00};
    bus(0, 8'h24, ctl);
    bus(0, 8'h20, 16'h2000);
    clkEn <= 1'b0;
    fork
      bus(0, 8'h3c, 16'h3000);
      begin
        repeat (4) @(posedge clock);
        clkEn <= 1'b1;
      end
    join
    repeat (4) @(posedge clock);
    close_out;
  end
endmodule
